/* File: pkg/power_switch_pkg.sv */
/*
  Constants shared by the power switch and reset controller and its pin qualifier.
  Assumes the 200 MHz system clock; all long delays run on a 1 ms time base.
*/
package power_switch_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_MS = 1;
  localparam int TICK_W = 14;

  localparam int DEBOUNCE_MS = 10;
  localparam int RESET_PULSE_MS = 10;
  localparam int RESET_DELAY_MS = 200;
  localparam int KEY_ON_SHORT_MS = 400;
  localparam int KEY_ON_LONG_MS = 3000;
  localparam int KEY_RESET_MS = 10000;
  localparam int KEY_OFF_MS = 12000;

  localparam logic [TICK_W-1:0] DEBOUNCE_LAST = TICK_W'(DEBOUNCE_MS / TICK_MS - 1);
  // One extra tick: the first tick may arrive early, so the pulse never runs short
  localparam logic [TICK_W-1:0] PULSE_LOAD = TICK_W'(RESET_PULSE_MS / TICK_MS + 1);
  localparam logic [TICK_W-1:0] RESET_DELAY_TICKS = TICK_W'(RESET_DELAY_MS / TICK_MS);
  localparam logic [TICK_W-1:0] KEY_ON_SHORT_TICKS = TICK_W'(KEY_ON_SHORT_MS / TICK_MS);
  localparam logic [TICK_W-1:0] KEY_ON_LONG_TICKS = TICK_W'(KEY_ON_LONG_MS / TICK_MS);
  localparam logic [TICK_W-1:0] KEY_RESET_TICKS = TICK_W'(KEY_RESET_MS / TICK_MS);
  localparam logic [TICK_W-1:0] KEY_OFF_TICKS = TICK_W'(KEY_OFF_MS / TICK_MS);

  // ----------------------------------------------------------------
  // Pin behaviour select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_LEVEL_HI = 4'h0;
  localparam logic [3:0] CFG_LEVEL_LO = 4'h1;
  localparam logic [3:0] CFG_AON_RISE = 4'h2;
  localparam logic [3:0] CFG_AON_FALL = 4'h3;
  localparam logic [3:0] CFG_KEY_ONOFF = 4'h6;
  localparam logic [3:0] CFG_KEY_RESET_A = 4'h7;
  localparam logic [3:0] CFG_KEY_RESET_B = 4'h8;
  localparam logic [3:0] CFG_LAST = 4'hc;

  // ----------------------------------------------------------------
  // Power command codes
  // ----------------------------------------------------------------
  localparam int CMD_W = 8;
  localparam logic [CMD_W-1:0] CMD_ENTER_OFF = 8'h01;
  localparam logic [CMD_W-1:0] CMD_ENTER_SEAL = 8'h02;
  localparam logic [CMD_W-1:0] CMD_ENTER_RECOVERY = 8'h03;

  typedef enum logic [2:0] {ST_BOOT, ST_ON, ST_OFF, ST_SEAL, ST_RECOVERY} state_e;

endpackage : power_switch_pkg

/* File: logic/pin_qualifier.sv */
/*
  Synchroniser, debounce and press-duration counter for one power-function pin.
  Assumes a one-cycle tick from the owner once per millisecond.
*/
`timescale 1ns/1ps
module pin_qualifier
  import power_switch_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic tick_i,
  input wire logic active_high_i,
  output logic sync_o,
  output logic active_o,
  output logic [TICK_W-1:0] held_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic settled;
    logic [TICK_W-1:0] db_cnt;
    logic [TICK_W-1:0] held;
  } qual_s;

  qual_s st;
  qual_s next_st;

  // ----------------------------------------------------------------
  // Debounce and press timer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    if (st.s2 == st.level && st.settled) begin
      next_st.db_cnt = '0;
    end else if (tick_i) begin
      if (st.db_cnt == DEBOUNCE_LAST) begin
        next_st.level = st.s2; // RULE20
        next_st.settled = 1'b1;
        next_st.db_cnt = '0;
      end else begin
        next_st.db_cnt = st.db_cnt + 1'b1;
      end
    end
    // Cleared once the debounced level leaves its active level
    if (!next_st.settled || next_st.level != active_high_i) begin
      next_st.held = '0; // RULE20
    end else if (tick_i && st.held != '1) begin
      next_st.held = st.held + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.s2;
  assign active_o = st.settled && (st.level == active_high_i);
  assign held_o = st.held;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_debounce_wait : assert property ($changed(st.level) |-> $past(st.db_cnt) == DEBOUNCE_LAST) // RULE16
    else $error("debounced level changed before the debounce time");

endmodule : pin_qualifier

/* File: logic/power_switch_reset_control.sv */
/*
  Power switch and reset controller: power modes, soft and hard resets,
  reset pulse and regulator enables.
  Assumes pins and charger detect are asynchronous; commands come from
  logic on sys_clk_i as one-cycle write strobes.
*/
// Notes on behaviour
// RULE1 - Pins, commands and conditions trigger shutdown/reset
// RULE2 - Four-bit select picks pin behaviour, codes 0-12
// RULE3 - Off disables all, except RTC regulator when kept and first linear regulator when sequenced
// RULE4 - First linear regulator stays on when sequenced
// RULE5 - Seal turns every regulator and node off
// RULE6 - Soft reset drives 10ms reset pulse
// RULE7 - Soft reset policy bit chooses keep or defaults
// RULE8 - Hard reset reruns the full power-on sequence
// RULE9 - Cold boot without harvester enters seal
// RULE10 - Cold boot with harvester enters battery recovery
// RULE11 - Commands while on select off, seal, recovery
// RULE12 - Valid pin event enters off or recovery
// RULE13 - Qualified key press wakes from off/seal
// RULE14 - Charger voltage wakes from off/seal
// RULE15 - On mode enables system node and regulators
// RULE16 - Codes 0-1: debounced level on/off, pin b reset
// RULE17 - Codes 2-3: edges give delayed hard/soft reset
// RULE18 - Code 6: 400ms on, 12s off, key buffered
// RULE19 - Code 7: 3s on, 10s soft reset
// RULE20 - Pins synchronised; timers clear when condition ends
// RULE21 - Reset output low for pulse, retrigger restarts
`timescale 1ns/1ps
module power_switch_reset_control
  import power_switch_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic power_func_pin_a_i,
  input wire logic power_func_pin_b_i,
  input wire logic charger_input_i,
  input wire logic [3:0] pin_behaviour_select_i,
  input wire logic harvester_enable_i,
  input wire logic soft_reset_register_policy_i,
  input wire logic rtc_aon_cfg_bit_i,
  input wire logic rtc_left_on_i,
  input wire logic first_linear_reg_sequence_i,
  input wire logic cmd_write_i,
  input wire logic [CMD_W-1:0] cmd_code_i,
  output logic reset_n_o,
  output logic hard_reset_o,
  output logic register_defaults_o,
  output logic system_node_en_o,
  output logic regulators_en_o,
  output logic rtc_regulator_en_o,
  output logic first_linear_regulator_en_o,
  output logic key_out_n_o,
  output logic key_out_oe_o,
  output logic [2:0] power_mode_o
);

  localparam int TICK_CNT_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  typedef struct packed {
    state_e mode;
    logic chg_meta;
    logic chg;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic tick;
    logic a_prev;
    logic b_prev;
    logic pend_hard;
    logic pend_soft;
    logic [TICK_W-1:0] pend_cnt;
    logic [TICK_W-1:0] pulse;
    logic rst_n;
    logic hard_rst;
    logic reg_load;
    logic sys_en;
    logic reg_en;
    logic rtc_en;
    logic first_linear_regulator_en;
    logic key_out_n_oe;
  } ctrl_s;

  ctrl_s st;
  ctrl_s next_st;

  logic a_sync;
  logic a_act;
  logic b_act;
  logic [TICK_W-1:0] a_held;
  logic [TICK_W-1:0] b_held;
  logic a_hi;
  logic b_hi;
  logic key_cfg;
  logic rtc_keep;

  // ----------------------------------------------------------------
  // Pin qualification
  // ----------------------------------------------------------------
  assign a_hi = (pin_behaviour_select_i == CFG_LEVEL_HI) ||
                (pin_behaviour_select_i == CFG_AON_RISE);
  assign b_hi = (pin_behaviour_select_i == CFG_AON_RISE);
  assign key_cfg = (pin_behaviour_select_i == CFG_KEY_ONOFF) ||
                   (pin_behaviour_select_i == CFG_KEY_RESET_A);
  assign rtc_keep = !rtc_aon_cfg_bit_i || rtc_left_on_i;

  pin_qualifier u_pin_a (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(power_func_pin_a_i),
    .tick_i(st.tick),
    .active_high_i(a_hi),
    .sync_o(a_sync),
    .active_o(a_act),
    .held_o(a_held)
  );

  pin_qualifier u_pin_b (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(power_func_pin_b_i),
    .tick_i(st.tick),
    .active_high_i(b_hi),
    .sync_o(),
    .active_o(b_act),
    .held_o(b_held)
  );

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  always_comb begin
    logic start_pulse;
    logic fire;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    state_e off_tgt;
    start_pulse = 1'b0;
    fire = (st.pend_hard || st.pend_soft) && (st.pend_cnt == RESET_DELAY_TICKS);
    a_rise = a_act && !st.a_prev;
    a_fall = !a_act && st.a_prev;
    b_rise = b_act && !st.b_prev;
    off_tgt = harvester_enable_i ? ST_RECOVERY : ST_OFF; // RULE12
    next_st = st;
    next_st.chg_meta = charger_input_i;
    next_st.chg = st.chg_meta;
    next_st.a_prev = a_act;
    next_st.b_prev = b_act;
    next_st.hard_rst = 1'b0;
    next_st.reg_load = 1'b0;
    next_st.tick = 1'b0;
    if (st.tick_cnt == TICK_LAST) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 1'b1;
    end
    if ((st.pend_hard || st.pend_soft) && st.tick) begin
      next_st.pend_cnt = st.pend_cnt + 1'b1; // RULE20
    end

    case (st.mode)
      ST_BOOT: begin
        start_pulse = 1'b1; // RULE8
        if (st.chg) begin
          next_st.mode = ST_ON;
        end else if (harvester_enable_i) begin
          next_st.mode = ST_RECOVERY; // RULE10
        end else begin
          next_st.mode = ST_SEAL; // RULE9
        end
      end
      ST_ON: begin
        if (cmd_write_i && cmd_code_i == CMD_ENTER_OFF) begin
          next_st.mode = ST_OFF; // RULE11
        end else if (cmd_write_i && cmd_code_i == CMD_ENTER_SEAL) begin
          next_st.mode = ST_SEAL; // RULE11
        end else if (cmd_write_i && cmd_code_i == CMD_ENTER_RECOVERY) begin
          next_st.mode = ST_RECOVERY; // RULE11
        end else if (fire) begin
          next_st.pend_hard = 1'b0;
          next_st.pend_soft = 1'b0;
          if (st.pend_hard) begin
            next_st.mode = ST_BOOT; // RULE8
            next_st.hard_rst = 1'b1;
          end else begin
            start_pulse = 1'b1; // RULE6
            next_st.reg_load = soft_reset_register_policy_i; // RULE7
          end
        end else begin
          case (pin_behaviour_select_i) // RULE2 RULE1
            CFG_LEVEL_HI, CFG_LEVEL_LO: begin
              if (a_fall) begin
                next_st.mode = off_tgt; // RULE16
              end else if (b_rise) begin
                start_pulse = 1'b1; // RULE16
                next_st.reg_load = soft_reset_register_policy_i;
              end
            end
            CFG_AON_RISE, CFG_AON_FALL: begin
              if (a_rise) begin
                next_st.pend_hard = 1'b1; // RULE17
                next_st.pend_soft = 1'b0;
                next_st.pend_cnt = '0;
              end else if (b_rise) begin
                next_st.pend_soft = 1'b1; // RULE17
                next_st.pend_hard = 1'b0;
                next_st.pend_cnt = '0;
              end
            end
            CFG_KEY_ONOFF: begin
              if (st.tick && a_held == KEY_OFF_TICKS) begin
                next_st.mode = off_tgt; // RULE18
              end
            end
            CFG_KEY_RESET_A: begin
              if (st.tick && a_held == KEY_RESET_TICKS) begin
                start_pulse = 1'b1; // RULE19
                next_st.reg_load = soft_reset_register_policy_i;
              end
            end
            CFG_KEY_RESET_B: begin
              if (st.tick && b_held == KEY_OFF_TICKS) begin
                start_pulse = 1'b1;
                next_st.reg_load = soft_reset_register_policy_i;
              end
            end
            default: begin
              next_st.mode = ST_ON;
            end
          endcase
        end
      end
      ST_OFF, ST_SEAL: begin
        if (st.chg) begin
          next_st.mode = ST_ON; // RULE14
          start_pulse = 1'b1;
        end else if (((pin_behaviour_select_i == CFG_LEVEL_HI ||
                       pin_behaviour_select_i == CFG_LEVEL_LO) && a_rise) ||
                     (pin_behaviour_select_i == CFG_KEY_ONOFF && st.tick &&
                      a_held == KEY_ON_SHORT_TICKS) || // RULE18
                     ((pin_behaviour_select_i == CFG_KEY_RESET_A ||
                       pin_behaviour_select_i == CFG_KEY_RESET_B) && st.tick &&
                      a_held == KEY_ON_LONG_TICKS)) begin // RULE19
          next_st.mode = ST_ON; // RULE13
          start_pulse = 1'b1;
        end
      end
      ST_RECOVERY: begin
        if (st.chg) begin
          next_st.mode = ST_ON;
          start_pulse = 1'b1;
        end
      end
      default: begin
        next_st.mode = ST_BOOT;
      end
    endcase

    if (next_st.mode != ST_ON) begin
      next_st.pend_hard = 1'b0;
      next_st.pend_soft = 1'b0;
    end
    if (start_pulse) begin
      next_st.pulse = PULSE_LOAD; // RULE21
    end else if (st.tick && st.pulse != '0) begin
      next_st.pulse = st.pulse - 1'b1;
    end
    next_st.rst_n = (next_st.pulse == '0); // RULE21

    // Node and regulator enables follow the mode being entered; the key output enable follows pin a in codes 6 and 7 only
    next_st.sys_en = (next_st.mode == ST_ON); // RULE15
    next_st.reg_en = (next_st.mode == ST_ON); // RULE15 RULE5
    next_st.rtc_en = (next_st.mode == ST_ON) ||
                     (next_st.mode == ST_OFF && rtc_keep); // RULE3
    next_st.first_linear_regulator_en = (next_st.mode == ST_ON) ||
                      (next_st.mode == ST_OFF && first_linear_reg_sequence_i); // RULE4
    next_st.key_out_n_oe = key_cfg && !a_sync; // RULE18
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reset_n_o = st.rst_n;
  assign hard_reset_o = st.hard_rst;
  assign register_defaults_o = st.reg_load;
  assign system_node_en_o = st.sys_en;
  assign regulators_en_o = st.reg_en;
  assign rtc_regulator_en_o = st.rtc_en;
  assign first_linear_regulator_en_o = st.first_linear_regulator_en;
  // Open drain: the pad only ever pulls low
  assign key_out_n_o = 1'b0;
  assign key_out_oe_o = st.key_out_n_oe;
  assign power_mode_o = st.mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_seal_dark : assert property (st.mode == ST_SEAL |-> !system_node_en_o && // RULE5
      !regulators_en_o && !rtc_regulator_en_o && !first_linear_regulator_en_o)
    else $error("output enabled in seal mode");
  a_off_rtc : assert property (st.mode == ST_OFF |-> // RULE3
      !system_node_en_o && rtc_regulator_en_o == $past(rtc_keep))
    else $error("wrong rtc regulator enable in off mode");
  a_off_first_linear_regulator : assert property (st.mode == ST_OFF |-> // RULE4
      first_linear_regulator_en_o == $past(first_linear_reg_sequence_i))
    else $error("wrong first regulator enable in off mode");
  a_on_power : assert property (st.mode == ST_ON |-> system_node_en_o && regulators_en_o) // RULE15
    else $error("system node off while on");
  a_cmd_seal : assert property (st.mode == ST_ON && cmd_write_i && // RULE11
      cmd_code_i == CMD_ENTER_SEAL |=> st.mode == ST_SEAL)
    else $error("seal command ignored");
  a_boot_seal : assert property (st.mode == ST_BOOT && !st.chg && // RULE9
      !harvester_enable_i |=> st.mode == ST_SEAL)
    else $error("cold boot did not enter seal");
  a_boot_recov : assert property (st.mode == ST_BOOT && !st.chg && // RULE10
      harvester_enable_i |=> st.mode == ST_RECOVERY)
    else $error("cold boot did not enter recovery");
  a_charger_wake : assert property ((st.mode == ST_OFF || st.mode == ST_SEAL) && // RULE14
      st.chg |=> st.mode == ST_ON ##0 !reset_n_o)
    else $error("charger did not wake the device");
  a_pulse_load : assert property ($fell(reset_n_o) |-> st.pulse == PULSE_LOAD) // RULE6
    else $error("reset pulse started without full length");
  a_pulse_hold : assert property (!reset_n_o && !st.tick |=> !reset_n_o) // RULE21
    else $error("reset pulse ended between ticks");
  a_soft_regs : assert property (register_defaults_o |-> // RULE7
      !reset_n_o && $past(soft_reset_register_policy_i))
    else $error("register defaults without soft reset");
  a_hard_boot : assert property (hard_reset_o |-> st.mode == ST_BOOT ##1 !reset_n_o) // RULE8
    else $error("hard reset did not rerun boot");

  c_cold_seal : cover property (st.mode == ST_BOOT ##1 st.mode == ST_SEAL);
  c_soft_pulse : cover property (st.mode == ST_ON && $fell(reset_n_o));
  c_key_wake : cover property (st.mode == ST_OFF && !st.chg ##1 st.mode == ST_ON);
  c_cmd_off : cover property (st.mode == ST_ON ##1 st.mode == ST_OFF);

endmodule : power_switch_reset_control

/* File: verification/host_side_model.sv */
/*
  Far side of the power switch block: key buttons, charger input and host command writer.
  Assumes the bench calls its tasks while sys_clk_i runs; every change lands 1 ns after a
  rising edge.
*/
`timescale 1ns/1ps
module host_side_model
  import power_switch_pkg::*;
(
  input wire logic sys_clk_i,
  output logic pin_a_o,
  output logic pin_b_o,
  output logic charger_o,
  output logic cmd_write_o,
  output logic [CMD_W-1:0] cmd_code_o
);
  // ----------------------------------------------------------------
  // Idle levels: buttons released, no charger, no write
  // ----------------------------------------------------------------
  initial begin
    pin_a_o = 1'b1;
    pin_b_o = 1'b1;
    charger_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = '0;
  end

  task automatic set_pins(input logic a, input logic b);
    @(posedge sys_clk_i);
    #1;
    pin_a_o = a;
    pin_b_o = b;
  endtask : set_pins

  task automatic set_charger(input logic v);
    @(posedge sys_clk_i);
    #1;
    charger_o = v;
  endtask : set_charger

  // One-cycle write; code is scrambled once the strobe is gone
  task automatic command(input logic [CMD_W-1:0] code);
    @(posedge sys_clk_i);
    #1;
    cmd_write_o = 1'b1;
    cmd_code_o = code;
    @(posedge sys_clk_i);
    #1;
    cmd_write_o = 1'b0;
    cmd_code_o = ~code;
  endtask : command
endmodule : host_side_model

/* File: verification/power_switch_reset_control_tb.sv */
/*
  Self-checking bench for the power switch and reset controller, with a mode model.
  Assumes the host side model and a shortened time base of TC cycles per tick.
*/
`timescale 1ns/1ps
module power_switch_reset_control_tb;
  import power_switch_pkg::*;
  localparam int TC = 2;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] sel = 4'h0;
  logic harv = 1'b0;
  logic policy = 1'b0;
  logic rtc_aon = 1'b1;
  logic rtc_left = 1'b0;
  logic fl_seq = 1'b0;
  logic pin_a, pin_b_drv, chg, cmd_wr;
  logic [CMD_W-1:0] cmd_code;
  logic reset_n, hard_rst, reg_def, sys_en, reg_en, rtc_en, fl_en, key_out_n_n, key_out_n_oe;
  logic [2:0] mode;
  logic [2:0] exp_mode = 3'h0;
  logic [CMD_W-1:0] codes [4];
  logic [2:0] exps [4];
  wire pin_b = key_out_n_oe ? key_out_n_n : pin_b_drv;
  int failures = 0;
  int cmp_count = 0;
  int n;

  always #2.5 sys_clk_i = ~sys_clk_i;

  host_side_model host_side_model_inst (.sys_clk_i(sys_clk_i), .pin_a_o(pin_a),
    .pin_b_o(pin_b_drv), .charger_o(chg), .cmd_write_o(cmd_wr), .cmd_code_o(cmd_code));

  power_switch_reset_control #(.TICK_CYCLES(TC)) power_switch_reset_control_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .power_func_pin_a_i(pin_a),
    .power_func_pin_b_i(pin_b), .charger_input_i(chg), .pin_behaviour_select_i(sel),
    .harvester_enable_i(harv), .soft_reset_register_policy_i(policy),
    .rtc_aon_cfg_bit_i(rtc_aon), .rtc_left_on_i(rtc_left),
    .first_linear_reg_sequence_i(fl_seq), .cmd_write_i(cmd_wr), .cmd_code_i(cmd_code),
    .reset_n_o(reset_n), .hard_reset_o(hard_rst), .register_defaults_o(reg_def),
    .system_node_en_o(sys_en), .regulators_en_o(reg_en), .rtc_regulator_en_o(rtc_en),
    .first_linear_regulator_en_o(fl_en), .key_out_n_o(key_out_n_n), .key_out_oe_o(key_out_n_oe),
    .power_mode_o(mode));

  // ----------------------------------------------------------------
  // Compare tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_state;
    logic on, off;
    on = (exp_mode == ST_ON);
    off = (exp_mode == ST_OFF);
    check_val({mode, sys_en, reg_en, rtc_en, fl_en}, {exp_mode, on, on,
      on | (off & (~rtc_aon | rtc_left)), on | (off & fl_seq)});
  endtask : check_state

  task automatic tick_wait(input bit hard, input logic [2:0] m, input int limit,
                           output int cnt);
    cnt = 0;
    while ((hard ? hard_rst !== 1'b1 : (m == 3'h7 ? reset_n !== 1'b0 : mode !== m))
           && cnt < limit) begin
      @(posedge sys_clk_i);
      #1;
      cnt++;
    end
  endtask : tick_wait

  task automatic wait_mode(input logic [2:0] m, input int limit);
    tick_wait(1'b0, m, limit, n);
    exp_mode = m;
    check_state();
  endtask : wait_mode

  task automatic check_pulse;
    int k;
    k = 0;
    check_val(reset_n, 1'b0);
    while (reset_n !== 1'b1 && k < 20 * TC) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    check_val(k >= 10 * TC - 2 && k <= 12 * TC + 2, 1'b1);
  endtask : check_pulse

  task automatic soft_reset(input int lo, input int hi);
    policy = 1'($urandom);
    tick_wait(1'b0, 3'h7, hi, n);
    check_val({n >= lo, reset_n, reg_def}, {1'b1, 1'b0, policy});
    check_pulse();
    check_state();
  endtask : soft_reset

  task automatic wake;
    host_side_model_inst.set_charger(1'b1);
    wait_mode(ST_ON, 10);
    check_pulse();
    host_side_model_inst.set_charger(1'b0);
  endtask : wake

  task automatic boot(input logic [3:0] s, input logic h, input logic pa, input logic pb);
    sel = s;
    harv = h;
    rst_i = 1'b1;
    host_side_model_inst.set_pins(pa, pb);
    host_side_model_inst.set_charger(1'b0);
    repeat (4) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    check_val({reset_n, mode}, 4'h0);
    wait_mode(h ? ST_RECOVERY : ST_SEAL, 10);
    repeat (30 * TC) @(posedge sys_clk_i);
    #1;
    wake();
  endtask : boot

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(59215));
    codes = '{CMD_ENTER_OFF, CMD_ENTER_SEAL, CMD_ENTER_RECOVERY, 8'($urandom_range(255, 4))};
    exps = '{ST_OFF, ST_SEAL, ST_RECOVERY, ST_ON};
    boot(4'h1, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      {rtc_aon, rtc_left, fl_seq} = 3'($urandom);
      host_side_model_inst.command(codes[i]);
      exp_mode = exps[i];
      check_state();
      if (i < 3) begin
        host_side_model_inst.command(codes[(i + 1) % 3]);
        check_state();
        wake();
      end
    end
    boot(4'h0, 1'b1, 1'b0, 1'b1);
    host_side_model_inst.set_pins(1'b0, 1'b0);
    soft_reset(9 * TC, 14 * TC + 10);
    boot(4'h2, 1'b1, 1'b0, 1'b0);
    host_side_model_inst.set_pins(1'b0, 1'b1);
    soft_reset(207 * TC, 212 * TC + 10);
    host_side_model_inst.set_pins(1'b1, 1'b1);
    tick_wait(1'b1, 3'h0, 212 * TC + 10, n);
    check_val({n >= 207 * TC, hard_rst, mode}, {1'b1, 1'b1, ST_BOOT});
    wait_mode(ST_RECOVERY, 10);
    boot(4'h6, 1'b0, 1'b1, 1'b1);
    host_side_model_inst.command(CMD_ENTER_OFF);
    exp_mode = ST_OFF;
    check_state();
    host_side_model_inst.set_pins(1'b0, 1'b1);
    repeat (4) @(posedge sys_clk_i);
    #1;
    check_val(pin_b, 1'b0);
    wait_mode(ST_ON, 412 * TC + 10);
    check_val(n >= 405 * TC, 1'b1);
    wait_mode(ST_OFF, 11700 * TC);
    check_val(n >= 11500 * TC, 1'b1);
    host_side_model_inst.set_pins(1'b1, 1'b1);
    repeat (4) @(posedge sys_clk_i);
    #1;
    check_val(key_out_n_oe, 1'b0);
    boot(4'h7, 1'b0, 1'b1, 1'b1);
    host_side_model_inst.set_pins(1'b0, 1'b1);
    soft_reset(9990 * TC, 10015 * TC);
    boot(4'h3, 1'b0, 1'b1, 1'b1);
    host_side_model_inst.set_pins(1'b0, 1'b1);
    tick_wait(1'b1, 3'h0, 212 * TC + 10, n);
    check_val({n >= 207 * TC, hard_rst, mode}, {1'b1, 1'b1, ST_BOOT});
    wait_mode(ST_SEAL, 10);
    boot(4'h8, 1'b0, 1'b1, 1'b1);
    host_side_model_inst.command(CMD_ENTER_SEAL);
    exp_mode = ST_SEAL;
    check_state();
    host_side_model_inst.set_pins(1'b0, 1'b1);
    wait_mode(ST_ON, 3012 * TC + 10);
    check_val({n >= 3005 * TC, key_out_n_oe}, 2'h2);
    summarize();
  end

  initial begin
    #400000;
    failures++;
    summarize();
  end
endmodule : power_switch_reset_control_tb
